// *** src/rxc_pkg.sv ***
// Purpose: Constants and types for the receiver configuration register bank
// Assumes: 125 MHz system clock, carrier tick pulse from the clock generator
// Notes: Shared by the register bank and by anything that decodes its map
// Notes on behaviour
// - Rate codes 4h..7h select 106..847 kBd
// - Unit 0 counts sixteen carrier periods
// - Unit 1 counts half a bit period
// - Ignore window after transmit end blanks input
// - Decoder accepts only levels at threshold or above
// - Phase detector uses its own minimum level
// - Bit 7 picks differential or single input
// - Bit 6 picks normal or card-detect converter
// - Source select feeds signal processing path
// - Collision strength fraction, code 3h disables
// - Two bits pick high-pass corner
// - Two bits pick amplifier gain step
package rxc_pkg;

    // ==========================================================
    // Register offsets
    localparam logic [7:0] RXC_OFS_RX_CONTROL   = 8'h35;
    localparam logic [7:0] RXC_OFS_WAIT_CFG     = 8'h36;
    localparam logic [7:0] RXC_OFS_THRESH_CFG   = 8'h37;
    localparam logic [7:0] RXC_OFS_MODE_CFG     = 8'h38;
    localparam logic [7:0] RXC_OFS_ANALOG_CFG   = 8'h39;
    localparam logic [7:0] RXC_OFS_STATUS       = 8'h3A;

    // ==========================================================
    // Writable bit masks, reserved positions are zero
    localparam logic [7:0] RXC_MASK_RX_CONTROL  = 8'h07;
    localparam logic [7:0] RXC_MASK_WAIT_CFG    = 8'hFF;
    localparam logic [7:0] RXC_MASK_THRESH_CFG  = 8'hFF;
    localparam logic [7:0] RXC_MASK_MODE_CFG    = 8'hF3;
    localparam logic [7:0] RXC_MASK_ANALOG_CFG  = 8'hCF;

    // ==========================================================
    // Values after reset
    localparam logic [7:0] RXC_RST_RX_CONTROL   = 8'h04;
    localparam logic [7:0] RXC_RST_WAIT_CFG     = 8'h00;
    localparam logic [7:0] RXC_RST_THRESH_CFG   = 8'h00;
    localparam logic [7:0] RXC_RST_MODE_CFG     = 8'h00;
    localparam logic [7:0] RXC_RST_ANALOG_CFG   = 8'h00;

    // ==========================================================
    // Field positions
    localparam int RXC_POS_WAIT_UNIT     = 7;
    localparam int RXC_POS_SINGLE_INPUT  = 7;
    localparam int RXC_POS_ADC_MODE      = 6;

    // ==========================================================
    // Rate codes
    localparam logic [2:0] RXC_RATE_106 = 3'h4;
    localparam logic [2:0] RXC_RATE_212 = 3'h5;
    localparam logic [2:0] RXC_RATE_424 = 3'h6;
    localparam logic [2:0] RXC_RATE_847 = 3'h7;

    // ==========================================================
    // Wait unit lengths in carrier periods
    localparam logic [6:0] RXC_UNIT_CARRIER  = 7'h10;
    localparam logic [6:0] RXC_HALF_BIT_106  = 7'h40;
    localparam logic [6:0] RXC_HALF_BIT_212  = 7'h20;
    localparam logic [6:0] RXC_HALF_BIT_424  = 7'h10;
    localparam logic [6:0] RXC_HALF_BIT_847  = 7'h08;

    // Collision off code
    localparam logic [1:0] RXC_COLL_OFF = 2'h3;

    // Status bit positions
    localparam int RXC_STS_IGNORE    = 0;
    localparam int RXC_STS_COLLISION = 1;
    localparam int RXC_STS_RATE_OK   = 2;

    // ==========================================================
    // Register bus request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } rxc_bus_req_type;

    // Signal source selections
    typedef enum logic [1:0] {
        RXC_SRC_IDLE     = 2'h0,
        RXC_SRC_ANALOG   = 2'h1,
        RXC_SRC_ENVELOPE = 2'h2,
        RXC_SRC_GENERIC  = 2'h3
    } rxc_src_type;

endpackage

// *** src/rxc_config_regs.sv ***
// Purpose: Receiver configuration register bank with post-transmit ignore timer
// Assumes: Bus strobes, carrier tick and strengths come from logic on i_ref_clk
// Notes: Read data appear one cycle after the read strobe, never a wait state
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module rxc_config_regs
    import rxc_pkg::*;
(
    // Clock and reset
    input  wire logic            i_ref_clk,
    input  wire logic            i_sys_rst,
    // Register bus
    input  wire rxc_bus_req_type i_bus,
    output logic [7:0]           o_rdata,
    output logic                 o_rdata_valid,
    // Receive path events and levels
    input  wire logic            i_carrier_tick,
    input  wire logic            i_tx_end,
    input  wire logic [3:0]      i_decoder_level,
    input  wire logic [3:0]      i_phase_level,
    input  wire logic [7:0]      i_main_strength,
    input  wire logic [7:0]      i_second_strength,
    // Decoded controls
    output logic [2:0]           o_rate_code,
    output logic                 o_rate_valid,
    output logic                 o_rx_ignore,
    output logic                 o_decoder_accept,
    output logic                 o_phase_accept,
    output logic                 o_single_input,
    output logic                 o_adc_low_power_card_detect,
    output rxc_src_type          o_sig_src,
    output logic                 o_collision,
    output logic [1:0]           o_midpoint_trim,
    output logic [1:0]           o_hpcf_sel,
    output logic [1:0]           o_gain_sel
);

    // ==========================================================
    // Storage
    logic [7:0] rx_control_r;      // Rate field only
    logic [7:0] wait_cfg_r;        // Unit select and ignore time
    logic [7:0] thresh_cfg_r;      // Decoder and phase thresholds
    logic [7:0] mode_cfg_r;        // Input, converter, source, collision
    logic [7:0] analog_cfg_r;      // Trim, corner, gain
    logic [6:0] ignore_cnt_r;      // Units left in the ignore window
    logic [6:0] unit_cnt_r;        // Carrier periods into current unit
    logic [6:0] unit_len;          // Length of one unit in carrier periods
    logic [7:0] coll_limit;        // Second-signal strength that flags collision
    logic [7:0] rdata_nxt;         // Read mux output
    logic       wr_hit;            // Any write this cycle

    // ==========================================================
    // Helper functions

    // Masked write keeps reserved positions at zero
    function automatic logic [7:0] masked(input logic [7:0] val, input logic [7:0] mask);
        masked = val & mask;
    endfunction

    // Half bit period of a rate code; reserved codes fall back to slowest
    function automatic logic [6:0] half_bit_len(input logic [2:0] code);
        unique case (code)
            RXC_RATE_106: half_bit_len = RXC_HALF_BIT_106;
            RXC_RATE_212: half_bit_len = RXC_HALF_BIT_212;
            RXC_RATE_424: half_bit_len = RXC_HALF_BIT_424;
            RXC_RATE_847: half_bit_len = RXC_HALF_BIT_847;
            default:      half_bit_len = RXC_HALF_BIT_106;
        endcase
    endfunction

    // Unsigned at-or-above compare for threshold levels
    function automatic logic level_ge(input logic [3:0] lvl, input logic [3:0] thr);
        level_ge = (lvl >= thr);
    endfunction

    assign wr_hit = i_bus.wr;

    // ==========================================================
    // Receive control register, rate field
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            rx_control_r <= RXC_RST_RX_CONTROL;
        end else if (wr_hit && (i_bus.addr == RXC_OFS_RX_CONTROL)) begin
            // Upper bits belong to other receive controls not held here
            rx_control_r <= masked(i_bus.wdata, RXC_MASK_RX_CONTROL);
        end
    end

    // ==========================================================
    // Wait configuration register
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            wait_cfg_r <= RXC_RST_WAIT_CFG;
        end else if (wr_hit && (i_bus.addr == RXC_OFS_WAIT_CFG)) begin
            wait_cfg_r <= masked(i_bus.wdata, RXC_MASK_WAIT_CFG);
        end
    end

    // ==========================================================
    // Threshold configuration register
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            thresh_cfg_r <= RXC_RST_THRESH_CFG;
        end else if (wr_hit && (i_bus.addr == RXC_OFS_THRESH_CFG)) begin
            // Noise margin is software's job, any value is taken
            thresh_cfg_r <= masked(i_bus.wdata, RXC_MASK_THRESH_CFG);
        end
    end

    // ==========================================================
    // Receiver mode register
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            mode_cfg_r <= RXC_RST_MODE_CFG;
        end else if (wr_hit && (i_bus.addr == RXC_OFS_MODE_CFG)) begin
            // Bits 3 to 2 are reserved and dropped
            mode_cfg_r <= masked(i_bus.wdata, RXC_MASK_MODE_CFG);
        end
    end

    // ==========================================================
    // Analog receive register
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            analog_cfg_r <= RXC_RST_ANALOG_CFG;
        end else if (wr_hit && (i_bus.addr == RXC_OFS_ANALOG_CFG)) begin
            // Trim is stored as written; nonzero values are a software fault
            analog_cfg_r <= masked(i_bus.wdata, RXC_MASK_ANALOG_CFG);
        end
    end

    // ==========================================================
    // Unit length for the ignore timer
    always_comb begin
        if (wait_cfg_r[RXC_POS_WAIT_UNIT]) begin
            // Half a bit period, follows the rate field live
            unit_len = half_bit_len(rx_control_r[2:0]);
        end else begin
            // Sixteen carrier periods
            unit_len = RXC_UNIT_CARRIER;
        end
    end

    // ==========================================================
    // Carrier period counter inside one unit
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            unit_cnt_r <= 7'h00;
        end else if (i_tx_end) begin
            // Restart the unit so the window aligns to the transmit end
            unit_cnt_r <= 7'h00;
        end else if ((ignore_cnt_r != 7'h00) && i_carrier_tick) begin
            if (unit_cnt_r >= (unit_len - 7'h01)) begin
                unit_cnt_r <= 7'h00;
            end else begin
                unit_cnt_r <= unit_cnt_r + 7'h01;
            end
        end
    end

    // ==========================================================
    // Ignore window, counts down whole units
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            ignore_cnt_r <= 7'h00;
        end else if (i_tx_end) begin
            // A zero time opens no window at all
            ignore_cnt_r <= wait_cfg_r[6:0];
        end else if ((ignore_cnt_r != 7'h00) && i_carrier_tick &&
                     (unit_cnt_r >= (unit_len - 7'h01))) begin
            ignore_cnt_r <= ignore_cnt_r - 7'h01;
        end
    end

    // Window flag, registered for a clean output
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            o_rx_ignore <= 1'b0;
        end else begin
            // Set from the transmit end itself so no input slips through
            o_rx_ignore <= (i_tx_end && (wait_cfg_r[6:0] != 7'h00)) ||
                           (!i_tx_end && (ignore_cnt_r != 7'h00) &&
                            !(i_carrier_tick && (ignore_cnt_r == 7'h01) &&
                              (unit_cnt_r >= (unit_len - 7'h01))));
        end
    end

    // ==========================================================
    // Rate decode
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            o_rate_code  <= RXC_RST_RX_CONTROL[2:0];
            o_rate_valid <= 1'b0;
        end else begin
            o_rate_code  <= rx_control_r[2:0];
            // Codes below 4h are reserved and flagged invalid
            o_rate_valid <= (rx_control_r[2:0] >= RXC_RATE_106);
        end
    end

    // ==========================================================
    // Threshold compares
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            o_decoder_accept <= 1'b0;
            o_phase_accept   <= 1'b0;
        end else begin
            // Blanked while the ignore window is open
            o_decoder_accept <= level_ge(i_decoder_level, thresh_cfg_r[7:4]) && !o_rx_ignore;
            o_phase_accept   <= level_ge(i_phase_level, thresh_cfg_r[3:0]) && !o_rx_ignore;
        end
    end

    // ==========================================================
    // Collision limit from selected fraction
    always_comb begin
        unique case (mode_cfg_r[1:0])
            2'h0:    coll_limit = {3'h0, i_main_strength[7:3]};
            2'h1:    coll_limit = {2'h0, i_main_strength[7:2]};
            2'h2:    coll_limit = {1'h0, i_main_strength[7:1]};
            default: coll_limit = 8'hFF;
        endcase
    end

    // Collision flag, off when disabled or inside the ignore window
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            o_collision <= 1'b0;
        end else begin
            // A zero second signal never counts, even against a tiny main signal
            o_collision <= (mode_cfg_r[1:0] != RXC_COLL_OFF) &&
                           (i_second_strength != 8'h00) &&
                           (i_second_strength >= coll_limit) &&
                           !o_rx_ignore;
        end
    end

    // ==========================================================
    // Mode and analog control outputs
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            o_single_input  <= 1'b0;
            o_adc_low_power_card_detect      <= 1'b0;
            o_sig_src       <= RXC_SRC_IDLE;
            o_midpoint_trim <= 2'h0;
            o_hpcf_sel      <= 2'h0;
            o_gain_sel      <= 2'h0;
        end else begin
            o_single_input  <= mode_cfg_r[RXC_POS_SINGLE_INPUT];
            o_adc_low_power_card_detect      <= mode_cfg_r[RXC_POS_ADC_MODE];
            o_sig_src       <= rxc_src_type'(mode_cfg_r[5:4]);
            o_midpoint_trim <= analog_cfg_r[7:6];
            o_hpcf_sel      <= analog_cfg_r[3:2];
            o_gain_sel      <= analog_cfg_r[1:0];
        end
    end

    // ==========================================================
    // Read mux
    always_comb begin
        unique case (i_bus.addr)
            RXC_OFS_RX_CONTROL: rdata_nxt = rx_control_r;
            RXC_OFS_WAIT_CFG:   rdata_nxt = wait_cfg_r;
            RXC_OFS_THRESH_CFG: rdata_nxt = thresh_cfg_r;
            RXC_OFS_MODE_CFG:   rdata_nxt = mode_cfg_r;
            RXC_OFS_ANALOG_CFG: rdata_nxt = analog_cfg_r;
            RXC_OFS_STATUS: begin
                // Live state, read only
                rdata_nxt = 8'h00;
                rdata_nxt[RXC_STS_IGNORE]    = o_rx_ignore;
                rdata_nxt[RXC_STS_COLLISION] = o_collision;
                rdata_nxt[RXC_STS_RATE_OK]   = o_rate_valid;
            end
            // Unmapped addresses read zero
            default: rdata_nxt = 8'h00;
        endcase
    end

    // ==========================================================
    // Read data register, valid one cycle after the strobe
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            o_rdata       <= 8'h00;
            o_rdata_valid <= 1'b0;
        end else begin
            o_rdata_valid <= i_bus.rd;
            // Zero outside read answers so the bus stays quiet
            o_rdata       <= i_bus.rd ? rdata_nxt : 8'h00;
        end
    end

endmodule // rxc_config_regs

`default_nettype wire

// *** tb/rxc_config_regs_assertions.sv ***
// Purpose: Port-level timing checks for the receiver configuration bank
// Assumes: Outputs lag their register by one cycle, reads answer in one cycle
// Notes: Sees only top-level ports, attached with bind below
`timescale 1ns/1ps
`default_nettype none
module rxc_config_regs_checker
    import rxc_pkg::*;
(
    // Clock, reset and bus
    input wire logic            i_ref_clk,
    input wire logic            i_sys_rst,
    input wire rxc_bus_req_type i_bus,
    input wire logic [7:0]      o_rdata,
    input wire logic            o_rdata_valid,
    // Watched controls
    input wire logic            i_tx_end,
    input wire logic [7:0]      i_second_strength,
    input wire logic [2:0]      o_rate_code,
    input wire logic            o_rate_valid,
    input wire logic            o_rx_ignore,
    input wire logic            o_single_input,
    input wire logic            o_adc_low_power_card_detect,
    input wire rxc_src_type     o_sig_src,
    input wire logic            o_collision,
    input wire logic [1:0]      o_midpoint_trim,
    input wire logic [1:0]      o_hpcf_sel,
    input wire logic [1:0]      o_gain_sel
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_sys_rst);
    // ==========================================================
    // A write to one offset not overwritten in the next cycle
    sequence s_wr(logic [7:0] a);
        (i_bus.wr && i_bus.addr == a) ##1 !(i_bus.wr && i_bus.addr == a);
    endsequence
    rd_answer_a: assert property (o_rdata_valid == $past(i_bus.rd)) else $error("read answer late");
    rd_idle_a: assert property (!o_rdata_valid |-> o_rdata == 8'h00) else $error("read data not idle");
    rate_write_a: assert property (s_wr(RXC_OFS_RX_CONTROL) |=>
        o_rate_code == $past(i_bus.wdata[2:0], 2) && o_rate_valid == $past(i_bus.wdata[2], 2))
        else $error("rate field wrong");
    mode_write_a: assert property (s_wr(RXC_OFS_MODE_CFG) |=> o_single_input == $past(i_bus.wdata[7], 2)
        && o_adc_low_power_card_detect == $past(i_bus.wdata[6], 2) && o_sig_src == $past(i_bus.wdata[5:4], 2))
        else $error("mode fields wrong");
    analog_write_a: assert property (s_wr(RXC_OFS_ANALOG_CFG) |=> o_gain_sel == $past(i_bus.wdata[1:0], 2)
        && o_hpcf_sel == $past(i_bus.wdata[3:2], 2) && o_midpoint_trim == $past(i_bus.wdata[7:6], 2))
        else $error("analog fields wrong");
    wait_rdback_a: assert property ((i_bus.wr && i_bus.addr == RXC_OFS_WAIT_CFG) ##1
        (i_bus.rd && i_bus.addr == RXC_OFS_WAIT_CFG) |=> o_rdata == $past(i_bus.wdata, 2))
        else $error("wait readback wrong");
    reset_vals_a: assert property ($fell(i_sys_rst) |-> o_rate_code == 3'h4 && !o_rx_ignore && !o_collision)
        else $error("reset outputs wrong");
    ignore_rise_a: assert property ($rose(o_rx_ignore) |-> $past(i_tx_end)) else $error("ignore without tx end");
    coll_src_a: assert property (o_collision |-> ($past(i_second_strength) != 8'h00
        || $past(i_second_strength, 2) != 8'h00)) else $error("collision without signal");
endmodule // rxc_config_regs_checker
bind rxc_config_regs rxc_config_regs_checker u_chk (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_bus(i_bus),
    .o_rdata(o_rdata), .o_rdata_valid(o_rdata_valid), .i_tx_end(i_tx_end), .i_second_strength(i_second_strength),
    .o_rate_code(o_rate_code), .o_rate_valid(o_rate_valid), .o_rx_ignore(o_rx_ignore),
    .o_single_input(o_single_input), .o_adc_low_power_card_detect(o_adc_low_power_card_detect), .o_sig_src(o_sig_src), .o_collision(o_collision),
    .o_midpoint_trim(o_midpoint_trim), .o_hpcf_sel(o_hpcf_sel), .o_gain_sel(o_gain_sel));
`default_nettype wire

// *** tb/rxc_carrier_model.sv ***
// Purpose: Far-side carrier time base, one tick per carrier period
// Assumes: 125 MHz clock, 13.56 MHz carrier rounded to a whole divider
// Notes: Divider is a plain default, close to 125/13.56
`timescale 1ns/1ps
`default_nettype none
module rxc_carrier_model #(
    parameter int DIV = 9 // Clock cycles per carrier period
) (
    // Clock and reset
    input  wire logic i_ref_clk,
    input  wire logic i_sys_rst,
    // Carrier tick pulse
    output var logic  o_tick
);
    logic [7:0] cnt_r; // Divider count
    // ==========================================================
    // Free-running carrier: the field runs whether or not a frame is on
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst || cnt_r == 8'(DIV - 1)) begin
            cnt_r <= 8'h00;
        end else begin
            cnt_r <= cnt_r + 8'h01;
        end
        o_tick <= !i_sys_rst && cnt_r == 8'(DIV - 1);
    end
endmodule // rxc_carrier_model
`default_nettype wire

// *** tb/tb.sv ***
// Purpose: Self-checking bench for the receiver configuration bank
// Assumes: Bus strobes one cycle, read data in the next cycle only
// Notes: Tick counts are exact, so window length slips show at once
`timescale 1ns/1ps
`default_nettype none
module tb;
    import rxc_pkg::*;
    logic            clk = 1'b0;     // 125 MHz clock
    logic            rst = 1'b1;     // Synchronous reset
    rxc_bus_req_type bus = '0;       // Bus request
    logic            tx_end = 1'b0;  // Transmit end pulse
    logic [3:0]      dlev = 4'h0;    // Decoder level
    logic [3:0]      plev = 4'h0;    // Phase level
    logic [7:0]      mstr = 8'h00;   // Main strength
    logic [7:0]      sstr = 8'h00;   // Second strength
    logic            tick;           // Carrier tick
    logic [7:0]      rdata;          // Read data
    logic            rvalid;         // Read data valid
    logic [2:0]      rate;           // Rate code
    logic            rate_ok;        // Rate valid
    logic            ign;            // Ignore window
    logic            dacc;           // Decoder accept
    logic            pacc;           // Phase accept
    logic            single;         // Single input
    logic            low_power_card_detect;           // Card detect mode
    rxc_src_type     src;            // Signal source
    logic            coll;           // Collision
    logic [1:0]      trim;           // Midpoint trim
    logic [1:0]      hpcf;           // High-pass corner
    logic [1:0]      gain;           // Gain step
    int              fail_count = 0;
    int              samples_checked = 0;
    int              cycles = 0;
    always #4 clk = ~clk;
    rxc_carrier_model u_car (.i_ref_clk(clk), .i_sys_rst(rst), .o_tick(tick));
    rxc_config_regs dut (.i_ref_clk(clk), .i_sys_rst(rst), .i_bus(bus), .o_rdata(rdata), .o_rdata_valid(rvalid),
        .i_carrier_tick(tick), .i_tx_end(tx_end), .i_decoder_level(dlev), .i_phase_level(plev),
        .i_main_strength(mstr), .i_second_strength(sstr), .o_rate_code(rate), .o_rate_valid(rate_ok),
        .o_rx_ignore(ign), .o_decoder_accept(dacc), .o_phase_accept(pacc), .o_single_input(single),
        .o_adc_low_power_card_detect(low_power_card_detect), .o_sig_src(src), .o_collision(coll), .o_midpoint_trim(trim), .o_hpcf_sel(hpcf),
        .o_gain_sel(gain));
    // ==========================================================
    // Shared tasks
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk) bus.wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe is taken
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk) bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk) bus.rd <= 1'b0;
        #1 chk({7'h00, rvalid}, 8'h01);
        chk(rdata, exp);
    endtask
    // Write then read the same offset with no gap between the strobes
    task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk) bus <= '{addr: a, wdata: d, wr: 1'b0, rd: 1'b1};
        @(posedge clk) bus.rd <= 1'b0;
        #1 chk({7'h00, rvalid}, 8'h01);
        chk(rdata, d);
    endtask
    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic wrap_up();
        $display("comparisons=%0d mismatches=%0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_reset_masks();
        logic [7:0] ofs [6] = '{8'h35, 8'h36, 8'h37, 8'h38, 8'h39, 8'h40};
        logic [7:0] msk [6] = '{8'h07, 8'hFF, 8'hFF, 8'hF3, 8'hCF, 8'h00};
        logic [7:0] rv  [6] = '{8'h04, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        rd_chk(8'h3A, 8'h04);
        for (int i = 0; i < 6; i++) rd_chk(ofs[i], rv[i]);
        for (int i = 0; i < 6; i++) wr(ofs[i], 8'hFF);
        for (int i = 0; i < 6; i++) rd_chk(ofs[i], msk[i]);
        wr(8'h39, 8'h00);
        $display("test reset_masks done");
    endtask
    task automatic t_fields();
        for (int c = 0; c < 8; c++) begin
            wr(8'h35, 8'(c));
            settle();
            chk({5'h00, rate}, 8'(c));
            chk({7'h00, rate_ok}, {7'h00, c >= 4});
        end
        for (int c = 0; c < 16; c++) begin
            wr(8'h38, {c[3:0], 4'h0});
            wr(8'h39, {4'h0, c[3:0]});
            settle();
            chk({6'h00, single, low_power_card_detect}, {6'h00, c[3:2]});
            chk({6'h00, src}, {6'h00, c[1:0]});
            chk({4'h0, hpcf, gain}, {4'h0, c[3:0]});
            chk({6'h00, trim}, 8'h00);
        end
        $display("test fields done");
    endtask
    task automatic t_ignore();
        logic [7:0] wt [3] = '{8'h02, 8'h81, 8'h82};
        logic [2:0] rt [3] = '{3'h4, 3'h7, 3'h6};
        int         ex [3] = '{32, 8, 32};
        int         n;
        for (int i = 0; i < 3; i++) begin
            wr(8'h35, {5'h00, rt[i]});
            wr_rd(8'h36, wt[i]);
            do @(posedge clk); while (tick !== 1'b1);
            tx_end <= 1'b1;
            @(posedge clk) tx_end <= 1'b0;
            @(posedge clk) #1 chk({7'h00, ign}, 8'h01);
            n = 0;
            for (int k = 0; k < 1000 && ign === 1'b1; k++) begin
                @(posedge clk) if (tick) n++;
                #1;
            end
            chk(8'(n), 8'(ex[i]));
        end
        $display("test ignore done");
    endtask
    task automatic t_thresh();
        wr(8'h37, 8'h53);
        dlev <= 4'h5;
        plev <= 4'h3;
        settle();
        chk({6'h00, dacc, pacc}, 8'h03);
        dlev <= 4'h4;
        plev <= 4'h2;
        settle();
        chk({6'h00, dacc, pacc}, 8'h00);
        $display("test thresh done");
    endtask
    task automatic t_coll();
        logic [7:0] lim;
        mstr <= 8'h80;
        for (int c = 0; c < 4; c++) begin
            lim = (c == 3) ? 8'h80 : 8'h80 >> (3 - c);
            wr(8'h38, 8'(c));
            sstr <= lim;
            settle();
            chk({7'h00, coll}, {7'h00, c != 3});
            sstr <= lim - 8'h01;
            settle();
            chk({7'h00, coll}, 8'h00);
        end
        $display("test coll done");
    endtask
    // ==========================================================
    // Hang guard: longest test needs under a thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            wrap_up();
        end
    end
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        t_reset_masks();
        t_fields();
        t_ignore();
        t_thresh();
        t_coll();
        wrap_up();
    end
endmodule // tb
`default_nettype wire
